// ### verilog/xbar_regs.vh
/*
 constants for the 4x4 crossbar: port counts, widths, field positions,
 mode encodings and the depth of the per-input request queue.
 assumes it is included by its bare name from the design files.
*/
`ifndef XBAR_REGS_VH
`define XBAR_REGS_VH

`define XB_PORTS        4
`define XB_WORD_W       20
`define XB_ADDR_W       2
`define XB_BUS_W        80
`define XB_SEL_W        8
`define XB_REQ_W        22
`define XB_REQ_ADDR_LSB 20
`define XB_FIFO_DEPTH   8
`define XB_FIFO_AW      3
`define XB_MODE_DIRECT  1'b0
`define XB_MODE_ARB     1'b1
`define XB_WORD_RST     20'h00000

`endif

// ### verilog/xbar_fifo.v
/*
 synchronous fifo of flip-flops with valid/ready on both sides.
 assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none

module xbar_fifo #(
    parameter WIDTH = 22,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             clk,
    input  wire             arst_n,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    wire            push;
    wire            pop;

    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ### verilog/xbar_out_slot.v
/*
 one output port latch of the crossbar: loads a word every cycle in direct
 mode, or on a grant in arbitration mode, and frees on acceptance.
 assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "xbar_regs.vh"

module xbar_out_slot (
    // clock and reset
    input  wire                   clk,
    input  wire                   arst_n,
    // control
    input  wire                   route_mode,
    input  wire [`XB_WORD_W-1:0]  direct_word,
    input  wire                   arb_load,
    input  wire [`XB_WORD_W-1:0]  arb_word,
    input  wire                   out_accepted,
    // port state
    output reg  [`XB_WORD_W-1:0]  word_r,
    output reg                    valid_r,
    output wire                   free
);

    // latch is free when empty or its word is being taken this cycle
    assign free = ~valid_r | out_accepted;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            word_r  <= `XB_WORD_RST;
            valid_r <= 1'b0;
        end else if (route_mode == `XB_MODE_DIRECT) begin
            word_r  <= direct_word;
            valid_r <= 1'b1;
        end else if (arb_load) begin
            word_r  <= arb_word;
            valid_r <= 1'b1;
        end else if (out_accepted) begin
            valid_r <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### verilog/crossbar_4x4_switch.v
/*
 4x4 crossbar of 20-bit words with direct routing and a handshaked mode
 with fixed-priority arbitration; each input owns an 8-deep request queue.
 assumes all inputs synchronous to clk; the sampling edge of clk stands for
 the capture edge and the output flops for the launch edge.
*/
// Overview of operation
// - four 20-bit inputs switched to outputs each cycle
// - one input may feed many outputs; one source each
// - mode low selects direct routing, no arbitration
// - direct mode: output address names its source input
// - direct mode: no decision delay, any fan-out
// - direct mode: input-taken driven low after first clock
// - contention: grant highest priority, hold the rest
// - taken raised when input holding stage has room
// - output valid high while output word valid
// - missing handshake stalls its output and every input queue whose head targets it
// - inputs captured on the sampling clock edge
// - outputs launched from flops, one cycle later
// - input/output latch pair acts as master-slave flop
`timescale 1ns/1ns
`default_nettype none
`include "xbar_regs.vh"

module crossbar_4x4_switch (
    // clock and reset
    input  wire                   clk,
    input  wire                   arst_n,
    // mode: low direct, high arbitration
    input  wire                   route_mode,
    // input ports, port n in bits n*20 +: 20
    input  wire [`XB_BUS_W-1:0]   in_port_word,
    input  wire [`XB_SEL_W-1:0]   port_addr_sel,
    input  wire [`XB_PORTS-1:0]   in_request_valid,
    output reg  [`XB_PORTS-1:0]   in_request_taken,
    // output ports
    output wire [`XB_BUS_W-1:0]   out_word,
    output wire [`XB_PORTS-1:0]   out_word_valid,
    input  wire [`XB_PORTS-1:0]   out_accepted
);

    wire [`XB_PORTS-1:0]          q_in_ready;
    wire [`XB_PORTS-1:0]          q_push;
    wire [`XB_PORTS-1:0]          head_valid;
    wire [`XB_REQ_W*4-1:0]        head_req;
    wire [`XB_PORTS-1:0]          slot_free;
    reg  [`XB_PORTS-1:0]          pop;
    reg  [`XB_PORTS-1:0]          grant;
    reg  [`XB_SEL_W-1:0]          win;
    reg  [`XB_BUS_W-1:0]          direct_bus;
    reg  [`XB_BUS_W-1:0]          arb_bus;
    reg  [`XB_PORTS-1:0]          taken_nxt;
    reg  [`XB_ADDR_W-1:0]         req_dest;
    reg  [`XB_ADDR_W-1:0]         src;
    integer                       i;
    integer                       o;

    ////////////////////////////////////////////////////////////////////////
    // request capture: one request per taken pulse, only with queue room
    assign q_push = in_request_valid & q_in_ready & ~in_request_taken
                    & {`XB_PORTS{route_mode == `XB_MODE_ARB}};

    always @* begin
        taken_nxt = q_push;
        if (route_mode == `XB_MODE_DIRECT) begin
            taken_nxt = {`XB_PORTS{1'b0}};
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            in_request_taken <= {`XB_PORTS{1'b0}};
        end else begin
            in_request_taken <= taken_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-input holding queues of {destination, word}
    genvar g;
    generate
        for (g = 0; g < `XB_PORTS; g = g + 1) begin : in_q
            xbar_fifo #(
                .WIDTH (`XB_REQ_W),
                .DEPTH (`XB_FIFO_DEPTH),
                .AW    (`XB_FIFO_AW)
            ) u_fifo (
                .clk       (clk),
                .arst_n    (arst_n),
                .in_valid  (q_push[g]),
                .in_ready  (q_in_ready[g]),
                .in_data   ({port_addr_sel[g*`XB_ADDR_W +: `XB_ADDR_W],
                             in_port_word[g*`XB_WORD_W +: `XB_WORD_W]}),
                .out_valid (head_valid[g]),
                .out_ready (pop[g]),
                .out_data  (head_req[g*`XB_REQ_W +: `XB_REQ_W])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // direct select and fixed-priority arbitration
    always @* begin
        direct_bus = {`XB_BUS_W{1'b0}};
        arb_bus    = {`XB_BUS_W{1'b0}};
        grant      = {`XB_PORTS{1'b0}};
        win        = {`XB_SEL_W{1'b0}};
        pop        = {`XB_PORTS{1'b0}};
        req_dest   = {`XB_ADDR_W{1'b0}};
        src        = {`XB_ADDR_W{1'b0}};
        for (o = 0; o < `XB_PORTS; o = o + 1) begin
            src = port_addr_sel[o*`XB_ADDR_W +: `XB_ADDR_W];
            direct_bus[o*`XB_WORD_W +: `XB_WORD_W] = in_port_word[src*`XB_WORD_W +: `XB_WORD_W];
            // scan from lowest priority up so input 0 wins last
            for (i = `XB_PORTS - 1; i >= 0; i = i - 1) begin
                req_dest = head_req[i*`XB_REQ_W + `XB_REQ_ADDR_LSB +: `XB_ADDR_W];
                if (head_valid[i] && req_dest == o[`XB_ADDR_W-1:0]) begin
                    grant[o]                       = 1'b1;
                    win[o*`XB_ADDR_W +: `XB_ADDR_W] = i[`XB_ADDR_W-1:0];
                end
            end
            if (grant[o] && slot_free[o] && route_mode == `XB_MODE_ARB) begin
                src                                   = win[o*`XB_ADDR_W +: `XB_ADDR_W];
                pop[src]                              = 1'b1;
                arb_bus[o*`XB_WORD_W +: `XB_WORD_W]   = head_req[src*`XB_REQ_W +: `XB_WORD_W];
            end else begin
                grant[o] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output latches, one per output port
    generate
        for (g = 0; g < `XB_PORTS; g = g + 1) begin : out_s
            xbar_out_slot u_slot (
                .clk          (clk),
                .arst_n       (arst_n),
                .route_mode   (route_mode),
                .direct_word  (direct_bus[g*`XB_WORD_W +: `XB_WORD_W]),
                .arb_load     (grant[g]),
                .arb_word     (arb_bus[g*`XB_WORD_W +: `XB_WORD_W]),
                .out_accepted (out_accepted[g]),
                .word_r       (out_word[g*`XB_WORD_W +: `XB_WORD_W]),
                .valid_r      (out_word_valid[g]),
                .free         (slot_free[g])
            );
        end
    endgenerate

endmodule

`default_nettype wire

// ### dv/crossbar_4x4_switch_asserts.sv
/* checker for the 4x4 crossbar, watching the top ports only.
 assumes one clock and the asynchronous active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module crossbar_4x4_switch_asserts (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // watched ports
    input wire logic        route_mode,
    input wire logic [79:0] in_port_word,
    input wire logic [7:0]  port_addr_sel,
    input wire logic [3:0]  in_request_valid,
    input wire logic [3:0]  in_request_taken,
    input wire logic [79:0] out_word,
    input wire logic [3:0]  out_word_valid,
    input wire logic [3:0]  out_accepted
);
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
a_reset_quiet: assert property ($rose(arst_n) |-> (out_word_valid | in_request_taken) == 4'h0)
    else $error("handshake outputs live at reset release");
a_reset_words: assert property ($rose(arst_n) |-> out_word == 80'h0)
    else $error("words live at reset release");
a_direct_taken: assert property (!route_mode |=> in_request_taken == 4'h0)
    else $error("taken raised in direct mode");
a_direct_valid: assert property (!route_mode |=> out_word_valid == 4'hF)
    else $error("direct output not valid");
for (genvar o = 0; o < 4; o++) begin : g_port
    a_direct_route: assert property (!route_mode |=>
        out_word[o*20+:20] == $past(in_port_word[port_addr_sel[o*2+:2]*20+:20])) else $error("direct word wrong");
    a_stall_hold: assert property (route_mode && out_word_valid[o] && !out_accepted[o] |=>
        out_word_valid[o] && $stable(out_word[o*20+:20])) else $error("stalled word lost");
    a_taken_pulse: assert property (in_request_taken[o] |=> !in_request_taken[o])
        else $error("taken longer than one cycle");
    a_taken_cause: assert property (in_request_taken[o] |-> $past(route_mode) && $past(in_request_valid[o]))
        else $error("taken without request");
end
c_contend: cover property (route_mode && in_request_valid == 4'hF);
c_stall: cover property (route_mode && out_word_valid[0] && !out_accepted[0]);
c_direct: cover property (!route_mode ##1 !route_mode);
endmodule
bind crossbar_4x4_switch crossbar_4x4_switch_asserts crossbar_4x4_switch_asserts_i (.clk(clk), .arst_n(arst_n),
    .route_mode(route_mode), .in_port_word(in_port_word), .port_addr_sel(port_addr_sel),
    .in_request_valid(in_request_valid), .in_request_taken(in_request_taken), .out_word(out_word),
    .out_word_valid(out_word_valid), .out_accepted(out_accepted));
`default_nettype wire

// ### dv/xbar_sink_model.sv
/* downstream receiver model driving the accept line of each output.
 assumes the bench names the outputs that stall in arbitration mode. */
`timescale 1ns/1ns
`default_nettype none
module xbar_sink_model (
    // clock and control
    input  wire logic       clk,
    input  wire logic       route_mode,
    input  wire logic [3:0] stall_mask,
    // handshake
    output var  logic [3:0] out_accepted
);
initial out_accepted = 4'h0;
always @(posedge clk) out_accepted <= route_mode ? ~stall_mask : 4'hF;
endmodule
`default_nettype wire

// ### dv/tb_crossbar_4x4_switch.sv
/* bench: contention, stall, full queue, random and direct traffic.
 assumes the sink model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,g) begin samples_checked++; if ((e) !== (g)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_crossbar_4x4_switch;
logic        clk = 0, arst_n = 0, route_mode = 1;
logic [79:0] in_port_word = 0, out_word;
logic [7:0]  port_addr_sel = 0;
logic [3:0]  in_request_valid = 0, in_request_taken, out_word_valid, out_accepted, stall_mask = 0;
logic [19:0] q[4][$], e;
logic [95:0] w;
logic [31:0] seed = 81;
int          num_errors = 0, samples_checked = 0, i, j, k;
crossbar_4x4_switch crossbar_4x4_switch_i (.clk(clk), .arst_n(arst_n), .route_mode(route_mode),
    .in_port_word(in_port_word), .port_addr_sel(port_addr_sel), .in_request_valid(in_request_valid),
    .in_request_taken(in_request_taken), .out_word(out_word), .out_word_valid(out_word_valid),
    .out_accepted(out_accepted));
xbar_sink_model xbar_sink_model_i (.clk(clk), .route_mode(route_mode), .stall_mask(stall_mask),
    .out_accepted(out_accepted));
function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
endfunction
// request from every port in m; destinations packed like port_addr_sel
task automatic send(input logic [3:0] m, input logic [7:0] dst, input logic ok);
    int n;
    logic [95:0] v;
    v = {rnd(), rnd(), rnd()};
    @(posedge clk);
    in_port_word <= v[79:0];
    port_addr_sel <= dst;
    in_request_valid <= m;
    for (n = 0; n < 10 && (in_request_taken & m) != m; n++) @(posedge clk);
    `CHK("taken", ok, (in_request_taken & m) == m)
    if (ok && (in_request_taken & m) != m) tally_and_finish();
    for (n = 0; n < 4; n++) if (ok && m[n]) q[dst[n*2+:2]].push_back(v[n*20+:20]);
    in_request_valid <= 4'h0;
endtask
task automatic drain();
    int n;
    for (n = 0; n < 40 && q[0].size() + q[1].size() + q[2].size() + q[3].size() != 0; n++) @(posedge clk);
    `CHK("drained", 1'b1, n < 40)
    if (n >= 40) tally_and_finish();
endtask
task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
initial forever #50 clk = ~clk;
always @(negedge clk) if (arst_n) for (k = 0; k < 4; k++) if (out_word_valid[k] && out_accepted[k]) begin
    if (q[k].size() == 0) `CHK("spare word", 1'b0, 1'b1)
    else begin
        e = q[k].pop_front();
        `CHK("out_word", e, out_word[k*20+:20])
    end
end
initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    stall_mask <= 4'h1;
    send(4'hF, 8'h00, 1'b1);
    send(4'h1, 8'h01, 1'b1);
    repeat (4) @(posedge clk);
    stall_mask <= 4'h0;
    drain();
    stall_mask <= 4'h4;
    for (i = 0; i < 9; i++) send(4'h8, 8'h80, 1'b1);
    send(4'h8, 8'h80, 1'b0);
    stall_mask <= 4'h0;
    drain();
    for (i = 0; i < 16; i++) begin
        w = {rnd(), rnd(), rnd()};
        send(4'h1 << w[1:0], w[9:2], 1'b1);
    end
    drain();
    for (i = 0; i <= 24; i++) begin
        @(posedge clk);
        if (i > 0) for (j = 0; j < 4; j++) q[j].push_back(in_port_word[port_addr_sel[j*2+:2]*20+:20]);
        w = {rnd(), rnd(), rnd()};
        in_port_word <= w[79:0];
        port_addr_sel <= w[87:80];
        route_mode <= (i == 24);
        in_request_valid <= (i == 24) ? 4'h0 : 4'hF;
    end
    drain();
    tally_and_finish();
end
endmodule
`default_nettype wire
